// ---- common/oaoc_pkg.sv ----
package oaoc_pkg;

   // register byte addresses
   localparam logic [11:0] OAOC_CSR_ADDR   = 12'h000;
   localparam logic [11:0] OAOC_RES_ADDR   = 12'h004;
   localparam logic [11:0] OAOC_STAT_ADDR  = 12'h008;
   localparam logic [11:0] OAOC_MASK_ADDR  = 12'h00C;

   // control/status field positions
   localparam int OAOC_DONE_BIT  = 7;
   localparam int OAOC_REQ_BIT   = 6;
   localparam int OAOC_AVG_BIT   = 5;
   localparam int OAOC_ON_BIT    = 4;
   localparam int OAOC_GAIN_BIT  = 3;

   localparam logic [7:0] OAOC_CSR_RESET = 8'h00;
   localparam logic [7:0] OAOC_CSR_WMASK = 8'h78;

   // event bits in status and mask registers
   localparam int OAOC_EV_DONE  = 0;
   localparam int OAOC_EV_NUM   = 1;

   localparam int OAOC_AVG_COUNT  = 16;
   localparam int OAOC_CYC_CYCLES = 64;
   localparam int OAOC_TRIM_W     = 6;

   typedef enum logic [1:0] {
      OAOC_IDLE = 2'b00,
      OAOC_RUN  = 2'b01,
      OAOC_HOLD = 2'b10
   } oaoc_state_t;

   typedef struct packed {
      logic       power;
      logic       highGain;
      logic       compActive;
      logic       outEn;
      logic       trimValid;
      logic [OAOC_TRIM_W-1:0] trim;
   } oaoc_amp_t;

endpackage : oaoc_pkg

// ---- core/oaoc_ctrl.sv ----
// Summary of operation
// - setting request starts an offset compensation cycle
// - hardware sets done flag when cycle ends
// - correction held only while request stays high
// - average select averages sixteen calculations
// - amplifier on connects input and output pins
// - amplifier off leaves output high impedance
// - input pins stay readable as digital inputs
// - done flag read-only bit 7, zero otherwise
// - request bit 6, average bit 5, writable
// - amplifier on bit 4, register resets zero
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module oaoc_ctrl
   import oaoc_pkg::*;
#(
   parameter int CYC_CYCLES = OAOC_CYC_CYCLES,
   parameter int AVG_COUNT  = OAOC_AVG_COUNT
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic [31:0]             prdata,
   // analog core
   input  wire logic [OAOC_TRIM_W-1:0] calcTrim,
   input  wire logic [1:0]         padIn,
   output oaoc_amp_t               amp,
   output logic                    ampOutOe,
   output logic [1:0]              padDigital,
   // interrupt
   output logic                    irq
);

   localparam int CNT_W = $clog2(CYC_CYCLES * AVG_COUNT + 1);
   localparam int SUM_W = OAOC_TRIM_W + 4;

   typedef struct packed {
      oaoc_state_t              state;
      logic [7:0]               csr;
      logic [CNT_W-1:0]         cnt;
      logic [4:0]               passes;
      logic                     avg;
      logic [SUM_W-1:0]         sum;
      logic [OAOC_TRIM_W-1:0]   trim;
      logic [OAOC_EV_NUM-1:0]   stat;
      logic [OAOC_EV_NUM-1:0]   mask;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      oaoc_amp_t                amp;
      logic                     ampOutOe;
      logic [1:0]               padDigital;
      logic                     irq;
   } oaoc_regs_t;

   oaoc_regs_t s_r;
   oaoc_regs_t s_nxt;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction : hit

   // register selected by an address
   typedef enum logic [2:0] {
      OAOC_SEL_CSR  = 3'b000,
      OAOC_SEL_RES  = 3'b001,
      OAOC_SEL_STAT = 3'b010,
      OAOC_SEL_MASK = 3'b011,
      OAOC_SEL_NONE = 3'b100
   } oaoc_sel_t;

   function automatic oaoc_sel_t decode(input logic [11:0] a);
      oaoc_sel_t sel;
      sel = OAOC_SEL_NONE;
      if (hit(a, OAOC_CSR_ADDR)) begin
         sel = OAOC_SEL_CSR;
      end
      if (hit(a, OAOC_RES_ADDR)) begin
         sel = OAOC_SEL_RES;
      end
      if (hit(a, OAOC_STAT_ADDR)) begin
         sel = OAOC_SEL_STAT;
      end
      if (hit(a, OAOC_MASK_ADDR)) begin
         sel = OAOC_SEL_MASK;
      end
      decode = sel;
   endfunction : decode

   // request bit of the control/status byte
   function automatic logic req_set(input logic [7:0] c);
      req_set = c[OAOC_REQ_BIT];
   endfunction : req_set

   // merge a software write into the control/status byte
   function automatic logic [7:0] csr_merge(
      input logic [7:0] cur,
      input logic [7:0] wr
   );
      logic [7:0] keep;
      logic [7:0] take;
      keep      = cur & ~OAOC_CSR_WMASK;
      take      = wr & OAOC_CSR_WMASK;
      csr_merge = keep | take;
   endfunction : csr_merge

   // number of calculations in one compensation cycle
   function automatic logic [4:0] pass_count(input logic avgSel);
      logic [4:0] n;
      if (avgSel) begin
         n = 5'(AVG_COUNT);
      end else begin
         n = 5'h01;
      end
      pass_count = n;
   endfunction : pass_count

   // correction: mean of the accumulated sum, or the single calculation
   function automatic logic [OAOC_TRIM_W-1:0] trim_result(
      input logic                   avgSel,
      input logic [SUM_W-1:0]       sum,
      input logic [OAOC_TRIM_W-1:0] last
   );
      logic [OAOC_TRIM_W-1:0] r;
      if (avgSel) begin
         r = sum[SUM_W-1:4];
      end else begin
         r = last;
      end
      trim_result = r;
   endfunction : trim_result

   // sticky event bits: a pending event wins over a read-clear
   function automatic logic [OAOC_EV_NUM-1:0] stat_update(
      input logic [OAOC_EV_NUM-1:0] cur,
      input logic                   clr,
      input logic [OAOC_EV_NUM-1:0] ev
   );
      logic [OAOC_EV_NUM-1:0] r;
      r           = clr ? '0 : cur;
      stat_update = r | ev;
   endfunction : stat_update

   // level interrupt while an unmasked event is pending
   function automatic logic irq_level(
      input logic [OAOC_EV_NUM-1:0] st,
      input logic [OAOC_EV_NUM-1:0] mk
   );
      irq_level = |(st & mk);
   endfunction : irq_level

   // drive of the analog core, taken from the next state
   function automatic oaoc_amp_t amp_drive(
      input oaoc_state_t            st,
      input logic [7:0]             c,
      input logic [OAOC_TRIM_W-1:0] t
   );
      oaoc_amp_t a;
      a.power      = c[OAOC_ON_BIT];
      a.highGain   = c[OAOC_GAIN_BIT];
      a.compActive = (st == OAOC_RUN);
      a.outEn      = c[OAOC_ON_BIT];
      a.trimValid  = (st == OAOC_HOLD);
      a.trim       = t;
      amp_drive    = a;
   endfunction : amp_drive

   logic                   access;
   logic                   doneEv;
   logic                   passEnd;
   logic                   statClr;
   logic [OAOC_EV_NUM-1:0] evVec;
   oaoc_sel_t              sel;
   logic [CNT_W-1:0]       cycLen;

   always_comb begin
      access = psel && penable && !s_r.pready;
      doneEv = 1'b0;
      passEnd = 1'b0;
      statClr = 1'b0;
      evVec  = '0;
      sel    = OAOC_SEL_NONE;
      cycLen = CNT_W'(CYC_CYCLES);
      s_nxt  = s_r;
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;

      // compensation sequencer
      case (s_r.state)
         OAOC_IDLE: begin
            if (req_set(s_r.csr)) begin
               s_nxt.state  = OAOC_RUN;
               s_nxt.cnt    = cycLen;
               s_nxt.avg    = s_r.csr[OAOC_AVG_BIT];
               s_nxt.passes = pass_count(s_r.csr[OAOC_AVG_BIT]);
               s_nxt.sum    = '0;
            end
         end
         OAOC_RUN: begin
            if (!req_set(s_r.csr)) begin
               // abort: nothing of this cycle is kept
               s_nxt.state = OAOC_IDLE;
               s_nxt.sum   = '0;
            end else if (s_r.cnt > CNT_W'(1)) begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end else begin
               passEnd = 1'b1;
            end
         end
         OAOC_HOLD: begin
            if (!req_set(s_r.csr)) begin
               // a new cycle needs the request to be set again
               s_nxt.state = OAOC_IDLE;
               s_nxt.trim  = '0;
            end
         end
         default: begin
            s_nxt.state = OAOC_IDLE;
         end
      endcase

      // one calculation finished: accumulate it
      if (passEnd) begin
         s_nxt.sum    = s_r.sum + SUM_W'(calcTrim);
         s_nxt.passes = s_r.passes - 5'h01;
         s_nxt.cnt    = cycLen;
         if (s_r.passes == 5'h01) begin
            s_nxt.state = OAOC_HOLD;
            doneEv      = 1'b1;
            s_nxt.trim  = trim_result(s_r.avg, s_nxt.sum, calcTrim);
         end
      end

      // register access
      sel = decode(paddr);
      if (access) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = '0;
         case (sel)
            OAOC_SEL_CSR: begin
               if (pwrite) begin
                  s_nxt.csr = csr_merge(s_nxt.csr, pwdata[7:0]);
               end else begin
                  s_nxt.prdata = {24'h000000, s_r.csr};
               end
            end
            OAOC_SEL_RES: begin
               if (!pwrite) begin
                  s_nxt.prdata = 32'(s_r.trim);
               end
            end
            OAOC_SEL_STAT: begin
               if (!pwrite) begin
                  s_nxt.prdata = 32'(s_r.stat);
                  statClr      = 1'b1;
               end
            end
            OAOC_SEL_MASK: begin
               if (pwrite) begin
                  s_nxt.mask = pwdata[OAOC_EV_NUM-1:0];
               end else begin
                  s_nxt.prdata = 32'(s_r.mask);
               end
            end
            default: begin
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // done reads zero once the request is gone
      s_nxt.csr[OAOC_DONE_BIT] = (s_nxt.state == OAOC_HOLD) &&
                                 req_set(s_nxt.csr);

      evVec[OAOC_EV_DONE] = doneEv;
      s_nxt.stat = stat_update(s_r.stat, statClr, evVec);
      s_nxt.irq  = irq_level(s_nxt.stat, s_nxt.mask);

      // analog side drive
      s_nxt.amp      = amp_drive(s_nxt.state, s_nxt.csr, s_nxt.trim);
      s_nxt.ampOutOe = s_nxt.csr[OAOC_ON_BIT];
      s_nxt.padDigital     = padIn;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r     <= '0;
         s_r.csr <= OAOC_CSR_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pready     = s_r.pready;
   assign pslverr    = s_r.pslverr;
   assign prdata     = s_r.prdata;
   assign amp        = s_r.amp;
   assign ampOutOe   = s_r.ampOutOe;
   assign padDigital = s_r.padDigital;
   assign irq        = s_r.irq;

endmodule : oaoc_ctrl

// ---- tb/oaoc_chk.sv ----
module oaoc_chk
   import oaoc_pkg::*;
(
   // watched ports
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       ampOutOe,
   input wire logic [1:0] padIn,
   input wire logic [1:0] padDigital,
   input wire oaoc_amp_t  amp
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence start_s; $rose(amp.compActive); endsequence
   sequence finish_s; ##[1:40] !amp.compActive; endsequence
   oe_on_a: assert property (ampOutOe == amp.power)
      else $error("output enable differs from power");
   out_hiz_a: assert property (amp.outEn == ampOutOe)
      else $error("output connect differs from enable");
   pad_read_a: assert property (!$past(rst) |-> padDigital == $past(padIn))
      else $error("pad level not passed through");
   ready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   run_bound_a: assert property (start_s |-> finish_s)
      else $error("compensation run too long");
   done_run_a: assert property ($rose(amp.trimValid) |->
      $past(amp.compActive) || $past(amp.compActive, 2))
      else $error("result valid without a run");
   trim_drop_a: assert property ($fell(amp.trimValid) |-> amp.trim == '0)
      else $error("correction kept after request cleared");
   hold_idle_a: assert property (amp.trimValid |-> !amp.compActive)
      else $error("result valid while running");
endmodule : oaoc_chk
bind oaoc_ctrl oaoc_chk u_chk (.*);

// ---- tb/oaoc_amp_model.sv ----
module oaoc_amp_model
   import oaoc_pkg::*;
#(
   parameter logic [5:0] TRIM = 6'h2B
) (
   // analog core side
   input  wire logic       mclk,
   input  wire oaoc_amp_t  amp,
   output logic [5:0]      calcTrim,
   output logic [1:0]      padIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt = 2'h0;
   always @(posedge mclk) cnt <= cnt + 2'h1;
   // trim only meaningful while a pass runs
   assign calcTrim = amp.compActive ? TRIM : ~TRIM ^ {4'h0, cnt};
   assign padIn    = cnt;
endmodule : oaoc_amp_model

// ---- tb/oaoc_ctrl_tb.sv ----
module oaoc_ctrl_tb;
   import oaoc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] TRIM = 6'h2B;
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, irq, ampOutOe, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [5:0] calcTrim;
   logic [1:0] padIn, padDigital;
   oaoc_amp_t amp;
   int fails = 0, checks_done = 0;
   oaoc_ctrl #(.CYC_CYCLES(2)) u_dut (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .calcTrim(calcTrim),
      .padIn(padIn), .amp(amp), .ampOutOe(ampOutOe),
      .padDigital(padDigital), .irq(irq));
   oaoc_amp_model #(.TRIM(TRIM)) u_amp (
      .mclk(mclk), .amp(amp), .calcTrim(calcTrim), .padIn(padIn));
   initial forever #12.5 mclk = ~mclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [11:0] a, input int d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : acc
   task automatic wait_done;
      repeat (60) begin
         acc(0, OAOC_CSR_ADDR, 0);
         if (q[7] === 1) break;
      end
   endtask : wait_done
   task automatic close_out;
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 0;
      acc(0, OAOC_CSR_ADDR, 0);
      chk(q, 32'h00);
      acc(1, OAOC_CSR_ADDR, 32'h8F);
      acc(0, OAOC_CSR_ADDR, 0);
      chk(q, 32'h08);
      chk(amp.highGain, 1);
      acc(1, OAOC_MASK_ADDR, 1);
      acc(1, OAOC_CSR_ADDR, 32'h50);
      wait_done;
      chk(q, 32'hD0);
      acc(0, OAOC_RES_ADDR, 0);
      chk(q, {26'h0, TRIM});
      @(negedge mclk);
      chk(ampOutOe, 1);
      chk(amp.power, 1);
      chk(irq, 1);
      acc(0, OAOC_STAT_ADDR, 0);
      chk(q, 32'h01);
      acc(0, OAOC_STAT_ADDR, 0);
      chk(q, 32'h00);
      @(negedge mclk);
      chk(irq, 0);
      acc(1, OAOC_CSR_ADDR, 32'h10);
      acc(0, OAOC_CSR_ADDR, 0);
      chk(q, 32'h10);
      chk(amp.trimValid, 0);
      acc(0, OAOC_RES_ADDR, 0);
      chk(q, 32'h00);
      acc(1, OAOC_CSR_ADDR, 32'h70);
      acc(0, OAOC_CSR_ADDR, 0);
      chk(q, 32'h70);
      wait_done;
      chk(q, 32'hF0);
      acc(0, OAOC_RES_ADDR, 0);
      chk(q, {26'h0, TRIM});
      acc(0, 12'h010, 0);
      chk(err, 1);
      acc(1, OAOC_CSR_ADDR, 0);
      acc(0, OAOC_CSR_ADDR, 0);
      chk(q, 32'h00);
      chk(ampOutOe, 0);
      chk(amp.outEn, 0);
      close_out;
   end
   initial begin
      #100000;
      fails++;
      close_out;
   end
endmodule : oaoc_ctrl_tb
